// *** src/adc_seq_pkg.sv ***
/*
  Constants, timing counts and state codes for the simultaneous-sampling converter sequencer.
  Assumes a single 20 MHz system clock; all times are converted to cycles of that clock.
*/
// Summary of operation
// - Internal clock: each selected channel converts within 2.4 us.
// - External 5 MHz conversion clock: each channel converts within 3.2 us.
// - Busy lasts at most selected channel count times one conversion time.
// - Busy rises within 70 ns of the start strobe rising edge.
// - First-result flag follows the output pointer within 70 ns of read rising.
// - First-result flag goes low within 15 ns of end-of-conversion falling.
// - Data outputs release 5 to 30 ns after read strobe rises.
// - Written data is taken at write strobe rising; host sets up 5 ns before.
// - Busy stays high from start until every selected channel is converted.
// - Start rising edge holds all inputs, starts conversion, latches selection.
// - First-result flag is high while the pointer addresses result one; here it is also held low until a result is stored and while eoc_n_o is low.
package adc_seq_pkg;
  localparam int DATA_W = 14;
  localparam int NCH = 4;
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CONV_INT_NS = 2400;
  localparam int T_CONV_EXT_NS = 3200;
  localparam int EXT_CLK_KHZ = 5000;
  localparam int T_BUSY_RISE_NS = 70;
  localparam int T_FLAG_RD_NS = 70;
  localparam int T_FLAG_EOC_NS = 15;
  localparam int T_RELEASE_MAX_NS = 30;
  localparam int T_EOC_MIN_NS = 120;
  // Longest times round down, least times round up, never below one cycle
  localparam int CONV_INT_CYC = T_CONV_INT_NS / CLK_PERIOD_NS;
  localparam int CONV_EXT_CYC = T_CONV_EXT_NS / CLK_PERIOD_NS;
  localparam int CONV_EXT_EDGES = T_CONV_EXT_NS * EXT_CLK_KHZ / 1000000;
  localparam int BUSY_RISE_CYC = (T_BUSY_RISE_NS / CLK_PERIOD_NS > 0) ? T_BUSY_RISE_NS / CLK_PERIOD_NS : 1;
  localparam int FLAG_RD_CYC = (T_FLAG_RD_NS / CLK_PERIOD_NS > 0) ? T_FLAG_RD_NS / CLK_PERIOD_NS : 1;
  localparam int FLAG_EOC_CYC = (T_FLAG_EOC_NS / CLK_PERIOD_NS > 0) ? T_FLAG_EOC_NS / CLK_PERIOD_NS : 1;
  localparam int RELEASE_CYC = (T_RELEASE_MAX_NS / CLK_PERIOD_NS > 0) ? T_RELEASE_MAX_NS / CLK_PERIOD_NS : 1;
  localparam int EOC_CYC = (T_EOC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SEL_RESET = 4'hf;
  localparam logic [3:0] SEL_EMPTY_DEFAULT = 4'h1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } seq_state_e;
endpackage

// *** src/adc_sequencer.sv ***
/*
  Converter sequencer top: start strobe, busy and end-of-conversion outputs, result store,
  parallel read port with first-result flag, and channel-select write port.
  Assumes all pins are synchronous to clk_i and the converter core presents sample_data_i
  for sample_chan_o when a conversion completes.
*/
`timescale 1ns/1ns
module adc_sequencer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic conversion_start_n_i,
  input wire logic standby_n_i,
  input wire logic ext_clk_sel_i,
  input wire logic ext_clk_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [adc_seq_pkg::NCH-1:0] data_i,
  input wire logic [adc_seq_pkg::DATA_W-1:0] sample_data_i,
  output logic busy_o,
  output logic eoc_n_o,
  output logic first_result_flag_o,
  output logic hold_o,
  output logic [1:0] sample_chan_o,
  output logic [adc_seq_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o
);
  import adc_seq_pkg::*;

  typedef struct packed {
    seq_state_e state;
    logic [3:0] sel;
    logic [3:0] run_sel;
    logic ext;
    logic [1:0] chan;
    logic [NCH-1:0][DATA_W-1:0] res;
    logic [2:0] n_done;
    logic [1:0] ptr;
    logic [1:0] eoc_cnt;
    logic busy;
    logic eoc_n;
    logic flag;
    logic start_q;
    logic rd_act;
    logic wr_act;
    logic [3:0] wr_data;
    logic [DATA_W-1:0] dout;
    logic oe;
  } seq_s;

  seq_s st;
  seq_s next_st;
  logic start_ok;
  logic tstart;
  logic tdone;
  logic read_end;
  logic wr_end;
  logic [2:0] nx;

  // Lowest selected channel at or above a position; bit 2 set means none left
  function automatic logic [2:0] find_sel(input logic [3:0] mask, input logic [2:0] from);
    logic [2:0] r;
    r = 3'b100;
    for (int i = 3; i >= 0; i--) begin
      if (mask[i] && 3'(i) >= from) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  conv_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(tstart),
    .ext_sel_i(next_st.ext),
    .ext_clk_i(ext_clk_i),
    .done_o(tdone)
  );

  always_comb begin
    next_st = st;
    nx = 3'b100;
    tstart = 1'b0;
    // Starts during standby or a running sequence are ignored
    start_ok = conversion_start_n_i & ~st.start_q & standby_n_i & (st.state == ST_IDLE);
    read_end = st.rd_act & rd_n_i;
    wr_end = st.wr_act & wr_n_i;
    next_st.start_q = conversion_start_n_i;
    next_st.rd_act = ~cs_n_i & ~rd_n_i;
    next_st.wr_act = ~cs_n_i & ~wr_n_i;
    if (next_st.wr_act) begin
      next_st.wr_data = data_i;
    end
    if (wr_end) begin
      next_st.sel = st.wr_data;
    end
    if (st.eoc_cnt != 2'b00) begin
      next_st.eoc_cnt = st.eoc_cnt - 2'b01;
    end
    if (read_end && st.n_done != 3'b000) begin
      next_st.ptr = (3'(st.ptr) + 3'b001 == st.n_done) ? 2'b00 : st.ptr + 2'b01;
    end
    unique case (st.state)
      ST_IDLE: begin
        if (start_ok) begin
          // Empty selection would leave busy with nothing to time
          next_st.run_sel = (st.sel == 4'h0) ? SEL_EMPTY_DEFAULT : st.sel;
          nx = find_sel(next_st.run_sel, 3'b000);
          next_st.chan = nx[1:0];
          next_st.ext = ext_clk_sel_i;
          next_st.n_done = 3'b000;
          next_st.ptr = 2'b00;
          next_st.busy = 1'b1;
          next_st.state = ST_CONV;
          tstart = 1'b1;
        end
      end
      ST_CONV: begin
        if (tdone) begin
          next_st.res[st.n_done[1:0]] = sample_data_i;
          next_st.n_done = st.n_done + 3'b001;
          next_st.eoc_cnt = 2'(EOC_CYC);
          nx = find_sel(st.run_sel, 3'(st.chan) + 3'b001);
          if (nx[2]) begin
            next_st.busy = 1'b0;
            next_st.state = ST_IDLE;
          end else begin
            next_st.chan = nx[1:0];
            tstart = 1'b1;
          end
        end
      end
      // Two of the four state codes are unused; recover to idle
      default: begin
        next_st.busy = 1'b0;
        next_st.state = ST_IDLE;
      end
    endcase
    next_st.eoc_n = (next_st.eoc_cnt == 2'b00);
    // Flag drops while a new result is landing, then follows the pointer
    next_st.flag = (next_st.ptr == 2'b00) && (next_st.n_done != 3'b000) && next_st.eoc_n;
    next_st.dout = next_st.res[next_st.ptr];
    next_st.oe = next_st.rd_act;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.sel <= SEL_RESET;
      st.run_sel <= SEL_RESET;
      st.eoc_n <= 1'b1;
      st.start_q <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;
  assign eoc_n_o = st.eoc_n;
  assign first_result_flag_o = st.flag;
  assign hold_o = st.busy;
  assign sample_chan_o = st.chan;
  assign data_o = st.dout;
  assign data_oe_o = st.oe;

  // Checking helpers
  logic [7:0] conv_cnt;
  logic [9:0] busy_cnt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_cnt <= 8'h00;
      busy_cnt <= 10'h000;
    end else begin
      conv_cnt <= tstart ? 8'h00 : conv_cnt + 8'h01;
      busy_cnt <= start_ok ? 10'h000 : busy_cnt + 10'h001;
    end
  end

  property p_conv_int;
    @(posedge clk_i) disable iff (!rst_n_i) tdone && !st.ext |-> conv_cnt == 8'(CONV_INT_CYC - 1);
  endproperty
  a_conv_int: assert property (p_conv_int) else $error("internal conversion time wrong");

  property p_conv_ext;
    @(posedge clk_i) disable iff (!rst_n_i) (st.state == ST_CONV) && st.ext |-> conv_cnt < 8'(CONV_EXT_CYC);
  endproperty
  a_conv_ext: assert property (p_conv_ext) else $error("external conversion too long");

  property p_busy_len;
    @(posedge clk_i) disable iff (!rst_n_i)
      busy_o && !st.ext |-> int'(busy_cnt) < $countones(st.run_sel) * CONV_INT_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy longer than channels times conversion");

  property p_busy_rise;
    @(posedge clk_i) disable iff (!rst_n_i) start_ok |=> busy_o && hold_o;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised after start");

  property p_flag_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
      read_end && !start_ok && !tdone && st.eoc_n && st.eoc_cnt == 2'b00 && st.n_done != 3'b000
      |=> first_result_flag_o == (st.ptr == 2'b00);
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag not updated after read");

  property p_flag_eoc;
    @(posedge clk_i) disable iff (!rst_n_i) $fell(eoc_n_o) |-> !first_result_flag_o;
  endproperty
  a_flag_eoc: assert property (p_flag_eoc) else $error("flag high at end of conversion");

  property p_release;
    @(posedge clk_i) disable iff (!rst_n_i) read_end |=> !data_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("data bus not released");

  property p_write;
    @(posedge clk_i) disable iff (!rst_n_i) wr_end |=> st.sel == $past(st.wr_data);
  endproperty
  a_write: assert property (p_write) else $error("write data not captured");

  property p_busy_done;
    @(posedge clk_i) disable iff (!rst_n_i) $fell(busy_o) |-> $past(tdone) && st.n_done == 3'($countones(st.run_sel));
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy fell before all channels");

  property p_latch_sel;
    @(posedge clk_i) disable iff (!rst_n_i) start_ok && st.sel != 4'h0 |=> st.run_sel == $past(st.sel);
  endproperty
  a_latch_sel: assert property (p_latch_sel) else $error("selection not latched at start");

  property p_first;
    @(posedge clk_i) disable iff (!rst_n_i)
      eoc_n_o && st.n_done != 3'b000 |-> first_result_flag_o == (st.ptr == 2'b00);
  endproperty
  a_first: assert property (p_first) else $error("flag does not track pointer");

  property p_advance;
    @(posedge clk_i) disable iff (!rst_n_i)
      read_end && !start_ok && st.n_done != 3'b000
      |=> st.ptr == (($past(st.ptr) == 2'($past(st.n_done) - 3'b001)) ? 2'b00 : $past(st.ptr) + 2'b01);
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance");
endmodule

// *** src/conv_timer.sv ***
/*
  Conversion timer: times one channel conversion from the system clock or from rising
  edges of an external conversion clock. Assumes ext_clk_i is synchronous to clk_i.
*/
`timescale 1ns/1ns
module conv_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic ext_sel_i,
  input wire logic ext_clk_i,
  output logic done_o
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic running;
    logic ext;
    logic ext_q;
    logic [5:0] cnt;
  } tmr_s;

  tmr_s st;
  tmr_s next_st;
  logic tick;

  always_comb begin
    next_st = st;
    tick = st.ext ? (ext_clk_i & ~st.ext_q) : 1'b1;
    done_o = st.running & tick & (st.cnt == 6'h00);
    next_st.ext_q = ext_clk_i;
    if (st.running && tick) begin
      if (st.cnt == 6'h00) begin
        next_st.running = 1'b0;
      end else begin
        next_st.cnt = st.cnt - 6'h01;
      end
    end
    // Restart wins over completion so back-to-back channels lose no cycle
    if (start_i) begin
      next_st.running = 1'b1;
      next_st.ext = ext_sel_i;
      next_st.cnt = ext_sel_i ? 6'(CONV_EXT_EDGES - 1) : 6'(CONV_INT_CYC - 1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// *** testbench/host_model.sv ***
/*
  Host-side partner: start strobe, parallel read and write cycles, external conversion clock.
  Assumes the sequencer samples every pin on rising edges of clk_i.
*/
`timescale 1ns/1ns
module host_model (
  input wire logic clk_i,
  input wire logic [adc_seq_pkg::DATA_W-1:0] data_i,
  input wire logic data_oe_i,
  input wire logic ext_run_i,
  output logic conv_n_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [3:0] sel_o,
  output logic ext_clk_o
);
  import adc_seq_pkg::*;
  logic [1:0] div;
  initial begin
    conv_n_o = 1'b1;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o = 4'h0;
    div = 2'h0;
    ext_clk_o = 1'b0;
  end
  // Four system cycles per period gives 5 MHz; still between frames
  always @(posedge clk_i) begin
    div <= ext_run_i ? div + 2'h1 : 2'h0;
    ext_clk_o <= div[1];
  end
  task automatic start();
    @(posedge clk_i);
    conv_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    conv_n_o <= 1'b1;
  endtask
  task automatic write_sel(input logic [3:0] v);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    sel_o <= v;
    repeat (2) @(posedge clk_i);
    wr_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    sel_o <= ~v;
  endtask
  // Two edges high after each read keep consecutive reads apart
  task automatic read(output logic [DATA_W-1:0] d, output logic oe, output logic oe_after);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    d = data_i;
    oe = data_oe_i;
    rd_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 oe_after = data_oe_i;
  endtask
endmodule

// *** testbench/simultaneous_sample_adc_sequencer_tb.sv ***
/*
  Self-checking bench for the converter sequencer: full and partial sequences, external clock, standby.
  Assumes the host model drives the bus and a core stand-in returns 14'h0100 plus the channel number.
*/
`timescale 1ns/1ns
module simultaneous_sample_adc_sequencer_tb;
  import adc_seq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic standby_n = 1'b1;
  logic ext_sel = 1'b0;
  logic ext_run = 1'b0;
  logic conv_n, cs_n, rd_n, wr_n, ext_clk, busy_o, eoc_n_o, first_result_flag_o, hold_o, data_oe_o;
  logic [3:0] sel;
  logic [1:0] sample_chan_o;
  logic [DATA_W-1:0] data_o;
  logic [DATA_W-1:0] sample_data = 14'h0000;
  int fail_count = 0;
  int tests_run = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) sample_data <= 14'h0100 + {12'h000, sample_chan_o};
  adc_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .conversion_start_n_i(conv_n),
    .standby_n_i(standby_n), .ext_clk_sel_i(ext_sel), .ext_clk_i(ext_clk), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(sel), .sample_data_i(sample_data), .busy_o(busy_o),
    .eoc_n_o(eoc_n_o), .first_result_flag_o(first_result_flag_o), .hold_o(hold_o),
    .sample_chan_o(sample_chan_o), .data_o(data_o), .data_oe_o(data_oe_o));
  host_model host (.clk_i(clk_i), .data_i(data_o), .data_oe_i(data_oe_o), .ext_run_i(ext_run),
    .conv_n_o(conv_n), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel), .ext_clk_o(ext_clk));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t ns: %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Slack covers the first external edge arriving a few cycles after start
  task automatic run_conv(input int n, input int cyc, input int slack);
    int k, eocs, flag_bad;
    logic prev;
    eocs = 0;
    flag_bad = 0;
    prev = 1'b1;
    host.start();
    @(posedge clk_i);
    #1 chk(busy_o === 1'b1 && hold_o === 1'b1, "busy or hold not raised");
    ext_run <= ext_sel;
    for (k = 0; k < 1000 && busy_o === 1'b1; k++) begin
      @(posedge clk_i);
      #1;
      if (prev === 1'b1 && eoc_n_o === 1'b0) eocs++;
      if (eoc_n_o === 1'b0 && first_result_flag_o !== 1'b0) flag_bad++;
      prev = eoc_n_o;
    end
    if (k >= 1000) begin
      chk(1'b0, "busy never fell");
      wrap_up();
    end
    chk(k <= n * cyc + slack && k > (n - 1) * cyc, "busy length");
    chk(eocs == n, "end-of-conversion count");
    chk(flag_bad == 0, "flag high during end-of-conversion");
    ext_run <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
  // One read past the last result checks the wrap
  task automatic read_all(input int n, input logic [7:0] chs);
    logic [DATA_W-1:0] d;
    logic oe, rel;
    for (int i = 0; i <= n; i++) begin
      chk(first_result_flag_o === (i % n == 0), "first flag");
      host.read(d, oe, rel);
      chk(d === 14'h0100 + chs[2*(i%n) +: 2] && oe === 1'b1 && rel === 1'b0, "read data");
    end
  endtask
  task automatic t_all();
    run_conv(4, CONV_INT_CYC, 1);
    read_all(4, 8'he4);
    $display("test all channels done");
  endtask
  task automatic t_subset();
    host.write_sel(4'h5);
    run_conv(2, CONV_INT_CYC, 1);
    read_all(2, 8'h08);
    $display("test subset done");
  endtask
  task automatic t_ext();
    @(posedge clk_i);
    ext_sel <= 1'b1;
    run_conv(2, CONV_EXT_CYC, 4);
    ext_sel <= 1'b0;
    read_all(2, 8'h08);
    $display("test external clock done");
  endtask
  task automatic t_standby();
    @(posedge clk_i);
    standby_n <= 1'b0;
    host.start();
    repeat (8) @(posedge clk_i);
    #1 chk(busy_o === 1'b0, "start taken in standby");
    host.write_sel(4'h0);
    @(posedge clk_i);
    standby_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    // Empty selection falls back to channel 0 alone
    run_conv(1, CONV_INT_CYC, 1);
    read_all(1, 8'h00);
    $display("test standby done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_all();
    t_subset();
    t_ext();
    t_standby();
    wrap_up();
  end
endmodule
